// ==== shared/pccr_dec_if.sv ====
// Bundle carrying the decode enables from the register core to decoder.
// Assumes both ends share clk_i.
`default_nettype none

interface pccr_dec_if;
  logic       mem_en;
  logic       io_en;
  logic [1:0] vga_map;

  modport regs (output mem_en, output io_en, output vga_map);
  modport dec  (input mem_en, input io_en, input vga_map);
endinterface

`default_nettype wire

// ==== shared/pccr_pkg.sv ====
// Constants for the host-bus command, class and revision registers.
// Assumes one 100 MHz clock and a configuration port of dword accesses.
//
// Overview of operation
// RULE1 - The system-error output is driven only while command bit 8 is set.
// RULE2 - Command bit 5 turns on palette snooping; at zero palette cycles are ordinary.
// RULE3 - Command bit 4 lets the master use write-and-invalidate, else plain write.
// RULE4 - With command bit 2 clear the block starts no master transactions.
// RULE5 - With command bit 1 clear no memory access is claimed; set, the 16MB windows and VGA memory are.
// RULE6 - The decoded VGA memory range follows bits 3:2 of the graphics misc register.
// RULE7 - Command bit 0 gates I/O decode of 0x3B0-0x3BB and 0x3C0-0x3DF with aliases.
// RULE8 - The category identifier fills bits 31:8 as base class, sub-class and interface bytes.
// RULE9 - The category identifier reads as 0x030000 and ignores writes.
// RULE10 - Bits 7:0 at dword 0x08 return a fixed maker-chosen revision value.
// RULE11 - Host software reads the class bytes to choose a generic driver.
// RULE12 - Status bit 30 is set whenever the system-error output is asserted.
// RULE13 - Reserved command bits read as zero and ignore writes.
// RULE14 - All writable command bits clear to zero at reset.
`default_nettype none

package pccr_pkg;
  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_OFS      = 8'h04;
  localparam logic [7:0]  REV_OFS      = 8'h08;
  localparam logic [7:0]  CAT_OFS      = 8'h09;
  localparam logic [15:0] CMD_WMASK    = 16'h0137;
  localparam logic [15:0] CMD_RESET    = 16'h0000;
  localparam int          SERR_BIT     = 8;
  localparam int          SNOOP_BIT    = 5;
  localparam int          MWI_BIT      = 4;
  localparam int          MASTER_BIT   = 2;
  localparam int          MEM_BIT      = 1;
  localparam int          IO_BIT       = 0;
  localparam int          RAISED_BIT   = 30;
  localparam logic [23:0] CATEGORY_ID  = 24'h030000;
  // Revision value is arbitrary
  localparam logic [7:0]  STEP_ID_DEF  = 8'h5a;
  // ----------------------------------------------------------------
  // Decode ranges
  // ----------------------------------------------------------------
  localparam logic [9:0]  IO_A_LO      = 10'h3b0;
  localparam logic [9:0]  IO_A_HI      = 10'h3bb;
  localparam logic [9:0]  IO_B_LO      = 10'h3c0;
  localparam logic [9:0]  IO_B_HI      = 10'h3df;
  localparam logic [31:0] VGA_A0000    = 32'h000a0000;
  localparam logic [31:0] VGA_B0000    = 32'h000b0000;
  localparam logic [31:0] VGA_B8000    = 32'h000b8000;
  localparam logic [31:0] VGA_C0000    = 32'h000c0000;
  localparam int          RST_STAGES   = 2;
endpackage

`default_nettype wire

// ==== sim/pccr_chk.sv ====
// Checker for the command, class and revision register block.
// Assumes it is bound to pccr_top and sees only that module's ports.
`default_nettype none

module pccr_chk
(
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        cfg_rd_i,
  input wire logic        cfg_wr_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        cfg_ack_o,
  input wire logic        tgt_mem_i,
  input wire logic        tgt_io_i,
  input wire logic        tgt_claim_o,
  input wire logic        mst_req_i,
  input wire logic        mst_line_wr_i,
  input wire logic        mst_start_o,
  input wire logic        mst_use_mwi_o,
  input wire logic        syserr_event_i,
  input wire logic        syserr_n_o,
  input wire logic        syserr_oe_n_o,
  input wire logic        syserr_raised_flag_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Reads of the two mapped dwords
  sequence s_rev_rd;
    cfg_rd_i && cfg_addr_i == pccr_pkg::REV_OFS;
  endsequence
  sequence s_cmd_rd;
    cfg_rd_i && cfg_addr_i == pccr_pkg::CMD_OFS;
  endsequence
  a_ack_one_cycle: assert property ((cfg_rd_i || cfg_wr_i) |=> cfg_ack_o)
    else $error("config ack missing");
  a_rev_fixed: assert property (s_rev_rd |=> cfg_rdata_o ==
    {pccr_pkg::CATEGORY_ID, pccr_pkg::STEP_ID_DEF})
    else $error("class or revision read wrong");
  a_rsvd_zero: assert property (s_cmd_rd |=>
    (cfg_rdata_o[15:0] & ~pccr_pkg::CMD_WMASK) == 16'h0000)
    else $error("reserved command bit read as one");
  a_serr_cause: assert property (!syserr_oe_n_o |->
    $past(syserr_event_i) && !syserr_n_o)
    else $error("system error driven without an event");
  a_raised_set: assert property (!syserr_oe_n_o |-> syserr_raised_flag_o)
    else $error("raised flag not set");
  a_start_cause: assert property (mst_start_o |-> $past(mst_req_i))
    else $error("master start without request");
  a_mwi_cause: assert property (mst_use_mwi_o |-> $past(mst_line_wr_i))
    else $error("invalidate write without line request");
  a_claim_kind: assert property (tgt_claim_o |->
    $past(tgt_mem_i || tgt_io_i))
    else $error("claim without an access");
endmodule

bind pccr_top pccr_chk u_pccr_chk (.*);

`default_nettype wire

// ==== sim/pccr_host_mdl.sv ====
// Host bridge model issuing single configuration cycles.
// Assumes the device takes a strobe on one rising edge.
`default_nettype none

module pccr_host_mdl
(
  input  wire logic  clk_i,
  output logic        cfg_rd_o = 1'b0,
  output logic        cfg_wr_o = 1'b0,
  output logic [7:0]  cfg_addr_o = 8'h00,
  output logic [3:0]  cfg_be_o = 4'h0,
  output logic [31:0] cfg_wdata_o = 32'h00000000
);
  // One cycle; released address and data show inverted values, byte enables keep theirs.
  // Drivers fetch class bytes with these dword reads
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_i);
    cfg_rd_o <= !wr;
    cfg_wr_o <= wr;
    cfg_addr_o <= a;
    cfg_be_o <= b;
    cfg_wdata_o <= d;
    @(posedge clk_i);
    cfg_rd_o <= 1'b0;
    cfg_wr_o <= 1'b0;
    cfg_addr_o <= ~a;
    cfg_wdata_o <= ~d;
  endtask
endmodule

`default_nettype wire

// ==== sim/tb_pccr_top.sv ====
// Self-checking bench for the command, class and revision registers.
// Assumes the host model drives the config port and this bench the rest.
`default_nettype none

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end

module tb_pccr_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, arst_n_i = 1'b0, rd_q = 1'b0, sticky = 1'b0;
  logic        cfg_rd, cfg_wr, cfg_ack, claim, start, mwi, snoop;
  logic        serr_n, serr_oe_n, raised;
  logic        tgt_mem = 1'b0, tgt_io = 1'b0, mst_req = 1'b0;
  logic        mst_lw = 1'b0, serr_ev = 1'b0;
  logic [7:0]  cfg_addr, bar0 = 8'h80, bar1 = 8'h90, vmisc = 8'h00;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, exp_v, tgt_addr = 32'h0;
  logic [31:0] exp_q[$];
  logic [15:0] c;
  int          n_errors = 0, checked = 0, cyc = 0, seed = 32'h919922fd;

  always #5 clk_i = ~clk_i;

  pccr_top u_pccr_top (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .cfg_rd_i(cfg_rd), .cfg_wr_i(cfg_wr), .cfg_addr_i(cfg_addr),
    .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata),
    .cfg_ack_o(cfg_ack), .tgt_addr_i(tgt_addr), .tgt_mem_i(tgt_mem),
    .tgt_io_i(tgt_io), .bar0_i(bar0), .bar1_i(bar1),
    .vga_graphics_misc_reg_i(vmisc), .tgt_claim_o(claim),
    .mst_req_i(mst_req), .mst_line_wr_i(mst_lw), .mst_start_o(start),
    .mst_use_mwi_o(mwi), .palette_snoop_o(snoop),
    .syserr_event_i(serr_ev), .syserr_n_o(serr_n),
    .syserr_oe_n_o(serr_oe_n), .syserr_raised_flag_o(raised));
  pccr_host_mdl u_pccr_host_mdl (.clk_i(clk_i), .cfg_rd_o(cfg_rd),
    .cfg_wr_o(cfg_wr), .cfg_addr_o(cfg_addr), .cfg_be_o(cfg_be),
    .cfg_wdata_o(cfg_wdata));

  // ----------------------------------------------------------------
  // Tasks, watcher and timeout
  // ----------------------------------------------------------------
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_pccr_host_mdl.access(1'b0, a, 4'hf, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    u_pccr_host_mdl.access(1'b1, a, b, d);
  endtask
  // Claim lands on the edge that samples the address, one edge after it is driven
  task automatic tgt(input logic m, input logic io, input logic [31:0] a);
    @(posedge clk_i);
    tgt_mem <= m;
    tgt_io <= io;
    tgt_addr <= a;
    @(posedge clk_i);
    #1;
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Read data stands only in the ack cycle, so it is taken there
  always @(posedge clk_i)
  begin
    rd_q <= cfg_rd;
    if (cfg_ack === 1'b1 && rd_q === 1'b1)
    begin
      exp_v = exp_q.pop_front();
      `CHK("rdata", exp_v, cfg_rdata)
    end
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(8'h04, 32'h0);
    rd(8'h08, {pccr_pkg::CATEGORY_ID, pccr_pkg::STEP_ID_DEF});
    wr(8'h08, 4'hf, $random(seed));
    rd(8'h08, {pccr_pkg::CATEGORY_ID, pccr_pkg::STEP_ID_DEF});
    wr(8'h04, 4'h3, 32'h0000ffff);
    rd(8'h04, {16'h0, pccr_pkg::CMD_WMASK});
    rd(8'h40, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      c = $random(seed);
      c[8] = i[0];
      wr(8'h04, 4'h3, {16'h0, c});
      mst_req <= 1'b1;
      mst_lw <= 1'b1;
      serr_ev <= 1'b1;
      tgt(1'b0, 1'b1, 32'h000007c4);
      `CHK("start", c[2], start)
      `CHK("mwi", c[4], mwi)
      `CHK("snoop", c[5], snoop)
      `CHK("serr_oe_n", ~c[8], serr_oe_n)
      `CHK("io claim", c[0], claim)
      sticky |= c[8];
      tgt(1'b1, 1'b0, {bar1, 24'h000123});
      `CHK("mem claim", c[1], claim)
    end
    serr_ev <= 1'b0;
    rd(8'h04, {1'b0, sticky, 14'h0, c & pccr_pkg::CMD_WMASK});
    wr(8'h04, 4'h8, 32'h40000000);
    rd(8'h04, {16'h0, c & pccr_pkg::CMD_WMASK});
    wr(8'h04, 4'h3, 32'h00000002);
    for (int m = 0; m < 4; m++)
    begin
      vmisc <= {4'h0, m[1:0], 2'h0};
      tgt(1'b1, 1'b0, pccr_pkg::VGA_B8000);
      `CHK("vga claim", 1'(m == 0 || m == 3), claim)
    end
    repeat (3) @(posedge clk_i);
    wrap_up();
  end
endmodule

`undef CHK
`default_nettype wire

// ==== src/pccr_decode.sv ====
// Target address decoder for memory windows, VGA memory and VGA I/O.
// Assumes addresses are held stable while the request is presented.
`default_nettype none

module pccr_decode
(
  pccr_dec_if.dec     en,
  input  wire logic [31:0] addr_i,
  input  wire logic        is_mem_i,
  input  wire logic        is_io_i,
  input  wire logic [7:0]  bar0_i,
  input  wire logic [7:0]  bar1_i,
  output logic             hit_o
);
  // Ten-bit compare keeps the aliases of the VGA ports
  function automatic logic in_rng(input logic [9:0] a,
                                  input logic [9:0] lo,
                                  input logic [9:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  logic io_hit;
  logic vga_hit;
  logic bar_hit;

  // VGA memory window follows the graphics misc map field
  always_comb
  begin
    case (en.vga_map) // see RULE6
      2'b00:   vga_hit = (addr_i >= pccr_pkg::VGA_A0000) &&
                         (addr_i <  pccr_pkg::VGA_C0000);
      2'b01:   vga_hit = (addr_i >= pccr_pkg::VGA_A0000) &&
                         (addr_i <  pccr_pkg::VGA_B0000);
      2'b10:   vga_hit = (addr_i >= pccr_pkg::VGA_B0000) &&
                         (addr_i <  pccr_pkg::VGA_B8000);
      default: vga_hit = (addr_i >= pccr_pkg::VGA_B8000) &&
                         (addr_i <  pccr_pkg::VGA_C0000);
    endcase
    bar_hit = (addr_i[31:24] == bar0_i) || (addr_i[31:24] == bar1_i);
    io_hit  = in_rng(addr_i[9:0], pccr_pkg::IO_A_LO, pccr_pkg::IO_A_HI) ||
              in_rng(addr_i[9:0], pccr_pkg::IO_B_LO, pccr_pkg::IO_B_HI);
  end

  // Claim only when the matching space is enabled
  assign hit_o = (is_mem_i && en.mem_en && (bar_hit || vga_hit)) || // see RULE5
                 (is_io_i && en.io_en && io_hit); // see RULE7
endmodule

`default_nettype wire

// ==== src/pccr_rst_sync.sv ====
// Two-stage reset release synchroniser.
// Assumes an active-low asynchronous reset input.
`default_nettype none

module pccr_rst_sync
(
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  output logic      rst_n_o
);
  logic [pccr_pkg::RST_STAGES-1:0] sync_q;
  logic [pccr_pkg::RST_STAGES-1:0] sync_d;

  // Shift in ones after release
  always_comb
  begin
    sync_d = {sync_q[pccr_pkg::RST_STAGES-2:0], 1'b1};
  end

  // Assert at once, release on the clock
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sync_q <= '0;
    else
      sync_q <= sync_d;
  end

  assign rst_n_o = sync_q[pccr_pkg::RST_STAGES-1];
endmodule

`default_nettype wire

// ==== src/pccr_top.sv ====
// Command, class code and revision registers of the host-bus header,
// with the enables they drive into target decode, master and error paths.
// Assumes configuration accesses are single-cycle dword strobes.
`default_nettype none

module pccr_top
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Configuration access port
  input  wire logic        cfg_rd_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic [31:0]      cfg_rdata_o,
  output logic             cfg_ack_o,
  // Target decode
  input  wire logic [31:0] tgt_addr_i,
  input  wire logic        tgt_mem_i,
  input  wire logic        tgt_io_i,
  input  wire logic [7:0]  bar0_i,
  input  wire logic [7:0]  bar1_i,
  input  wire logic [7:0]  vga_graphics_misc_reg_i,
  output logic             tgt_claim_o,
  // Master engine
  input  wire logic        mst_req_i,
  input  wire logic        mst_line_wr_i,
  output logic             mst_start_o,
  output logic             mst_use_mwi_o,
  output logic             palette_snoop_o,
  // System error
  input  wire logic        syserr_event_i,
  output logic             syserr_n_o,
  output logic             syserr_oe_n_o,
  output logic             syserr_raised_flag_o
);
  // ----------------------------------------------------------------
  // Reset and shared signals
  // ----------------------------------------------------------------
  logic        rst_n;
  logic        hit;
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic        raised_q;
  logic        raised_d;
  logic [31:0] rdata_d;
  logic        claim_d;
  logic        start_d;
  logic        mwi_d;
  logic        serr_d;

  pccr_dec_if dec_bus ();

  pccr_rst_sync u_rst
  (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .rst_n_o  (rst_n)
  );

  pccr_decode u_dec
  (
    .en       (dec_bus),
    .addr_i   (tgt_addr_i),
    .is_mem_i (tgt_mem_i),
    .is_io_i  (tgt_io_i),
    .bar0_i   (bar0_i),
    .bar1_i   (bar1_i),
    .hit_o    (hit)
  );

  // ----------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------
  // Only the low half of dword 0x04 belongs here; status half is apart
  always_comb
  begin
    cmd_d = cmd_q;
    if (cfg_wr_i && (cfg_addr_i == pccr_pkg::CMD_OFS))
    begin
      if (cfg_be_i[0])
        cmd_d[7:0] = cfg_wdata_i[7:0];
      if (cfg_be_i[1])
        cmd_d[15:8] = cfg_wdata_i[15:8];
    end
    cmd_d = cmd_d & pccr_pkg::CMD_WMASK; // see RULE13
  end

  // Raised flag: set wins over a write-one clear
  always_comb
  begin
    raised_d = raised_q;
    if (cfg_wr_i && (cfg_addr_i == pccr_pkg::CMD_OFS) && cfg_be_i[3] &&
        cfg_wdata_i[pccr_pkg::RAISED_BIT])
      raised_d = 1'b0;
    if (serr_d)
      raised_d = 1'b1; // see RULE12
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Class and revision share one dword; writes there change nothing
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (cfg_addr_i)
      pccr_pkg::CMD_OFS:
      begin
        rdata_d[15:0] = cmd_q; // see RULE13
        rdata_d[pccr_pkg::RAISED_BIT] = raised_q;
      end
      pccr_pkg::REV_OFS:
        rdata_d = {pccr_pkg::CATEGORY_ID, // see RULE8, RULE9
                   pccr_pkg::STEP_ID_DEF}; // see RULE10
      default:
        rdata_d = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Enables toward decoder, master and error driver
  // ----------------------------------------------------------------
  assign dec_bus.mem_en  = cmd_q[pccr_pkg::MEM_BIT];
  assign dec_bus.io_en   = cmd_q[pccr_pkg::IO_BIT];
  assign dec_bus.vga_map = vga_graphics_misc_reg_i[3:2];

  // Registered outputs are one cycle behind their causes
  always_comb
  begin
    claim_d = hit;
    start_d = mst_req_i && cmd_q[pccr_pkg::MASTER_BIT]; // see RULE4
    mwi_d   = mst_line_wr_i && cmd_q[pccr_pkg::MWI_BIT]; // see RULE3
    serr_d  = syserr_event_i && cmd_q[pccr_pkg::SERR_BIT]; // see RULE1
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_q                <= pccr_pkg::CMD_RESET; // see RULE14
      raised_q             <= 1'b0;
      cfg_rdata_o          <= 32'h0000_0000;
      cfg_ack_o            <= 1'b0;
      tgt_claim_o          <= 1'b0;
      mst_start_o          <= 1'b0;
      mst_use_mwi_o        <= 1'b0;
      palette_snoop_o      <= 1'b0;
      syserr_n_o           <= 1'b1;
      syserr_oe_n_o        <= 1'b1;
      syserr_raised_flag_o <= 1'b0;
    end
    else
    begin
      cmd_q                <= cmd_d;
      raised_q             <= raised_d;
      cfg_rdata_o          <= cfg_rd_i ? rdata_d : 32'h0000_0000;
      cfg_ack_o            <= cfg_rd_i || cfg_wr_i;
      tgt_claim_o          <= claim_d;
      mst_start_o          <= start_d;
      mst_use_mwi_o        <= mwi_d;
      palette_snoop_o      <= cmd_q[pccr_pkg::SNOOP_BIT]; // see RULE2
      syserr_n_o           <= ~serr_d;
      syserr_oe_n_o        <= ~serr_d; // see RULE1
      syserr_raised_flag_o <= raised_d;
    end
  end
endmodule

`default_nettype wire
